// *** verilog/switch_spi_defines.vh ***
`ifndef SWITCH_SPI_DEFINES_VH
`define SWITCH_SPI_DEFINES_VH

// Channel counts
`define SW_NCH            8
`define SW_NPAR           4

// Bit positions within the serial frame
`define SW_MSB            7
`define SW_LSB            0
`define SW_PAR_LO         0
`define SW_PAR_HI         3
`define SW_SER_LO         4
`define SW_SER_HI         7

// Reset values
`define SW_CTRL_RST       8'h00
`define SW_SHIFT_RST      8'h00
`define SW_PAR_OFF        4'h0

// Synchroniser depth
`define SW_SYNC_STAGES    2

// Thermal restart cycling, in core clock cycles
`define SW_THERM_CNT_W    16
`define SW_THERM_PERIOD   16'd20000
`define SW_THERM_ON       16'd2000

`endif

// *** verilog/pin_sync.v ***
`timescale 1ns/1ps
`include "switch_spi_defines.vh"

module pin_sync #(
  parameter W      = 1,           // Number of bits
  parameter [W-1:0] RST_VAL = {W{1'b0}}  // Value after reset
) (
  input  wire         clk_i,      // Core clock
  input  wire         rst_i,      // Synchronous reset, active high
  input  wire         ce_i,       // Clock enable
  input  wire [W-1:0] async_i,    // Signals from outside the domain
  output wire [W-1:0] sync_o      // Synchronised signals
);

  reg [W-1:0] meta_q;
  reg [W-1:0] stab_q;

  // Two flops per bit; the first is read only by the second
  genvar b;
  generate
    for (b = 0; b < W; b = b + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (rst_i) begin
          meta_q[b] <= RST_VAL[b];
          stab_q[b] <= RST_VAL[b];
        end else if (ce_i) begin
          meta_q[b] <= async_i[b];
          stab_q[b] <= meta_q[b];
        end
      end
    end
  endgenerate

  assign sync_o = stab_q;

endmodule

// *** verilog/channel_diag.v ***
`timescale 1ns/1ps
`include "switch_spi_defines.vh"

module channel_diag #(
  parameter [`SW_THERM_CNT_W-1:0] THERM_PERIOD = `SW_THERM_PERIOD,  // Restart period
  parameter [`SW_THERM_CNT_W-1:0] THERM_ON     = `SW_THERM_ON       // On slice per period
) (
  input  wire clk_i,              // Core clock
  input  wire rst_i,              // Synchronous reset
  input  wire ce_i,               // Clock enable
  input  wire on_i,               // Channel commanded on (serial or parallel)
  input  wire ctrl_bit_i,         // Latched serial control bit
  input  wire overload_i,         // Overload or short to supply sensed
  input  wire open_load_i,        // Open load or short to ground sensed
  input  wire overtemp_i,         // Channel over temperature
  input  wire ol_en_i,            // Open load detection enabled
  input  wire clear_i,            // Clear latched fault
  output reg  allow_o,            // Channel may conduct (thermal cycling)
  output wire diag_o,             // Diagnostic bit for the frame
  output wire fault_o             // Latched fault
);

  reg                       fault_q;
  reg [`SW_THERM_CNT_W-1:0] therm_cnt_q;
  wire                      fault_now;

  // Overload only matters while on, open load only while off
  assign fault_now = (on_i & overload_i) | (~on_i & open_load_i & ol_en_i);

  // Sticky fault; a new fault beats the clear in the same cycle
  always @(posedge clk_i) begin
    if (rst_i)
      fault_q <= 1'b0;
    else if (ce_i) begin
      if (fault_now)
        fault_q <= 1'b1;           // [R24]
      else if (clear_i)
        fault_q <= 1'b0;           // [R07]
    end
  end

  // Diagnostic follows the control bit, inverted under fault
  assign diag_o  = ctrl_bit_i ^ fault_q;   // [R23]
  assign fault_o = fault_q;

  // Low duty restart cycling for this channel only while hot
  always @(posedge clk_i) begin
    if (rst_i) begin
      therm_cnt_q <= {`SW_THERM_CNT_W{1'b0}};
      allow_o     <= 1'b1;
    end else if (ce_i) begin
      if (!overtemp_i) begin
        therm_cnt_q <= {`SW_THERM_CNT_W{1'b0}};
        allow_o     <= 1'b1;
      end else begin
        if (therm_cnt_q >= THERM_PERIOD - 1'b1)
          therm_cnt_q <= {`SW_THERM_CNT_W{1'b0}};
        else
          therm_cnt_q <= therm_cnt_q + 1'b1;
        allow_o <= (therm_cnt_q < THERM_ON);  // [R20]
      end
    end
  end

endmodule

// *** verilog/octal_switch_spi_control.v ***
// What this block does, and what it expects of the master
// R01: Sample serial input on serial clock falling edge
// R02: Advance serial output on serial clock rising edge
// R03: Control frame arrives MSB first, channel eight
// R04: Diagnostic bits leave MSB first, channel eight
// R05: Control bit one on, zero off
// R06: Select rise copies shift register into latches
// R07: Select rise clears latched diagnostic errors
// R08: Select fall loads diagnostics, starts accepting bits
// R09: Serial output floats while deselected, else drives
// R10: Deselected: ignore clock and data, hold register
// R11: Act on select rise only after clock
// R12: Master keeps clock low at select edges
// R13: Master holds select low for whole frame
// R14: Channels one-four: parallel input ORed with bit
// R15: Channels five-eight follow serial bits only
// R16: Control bit n drives channel n+1
// R17: Diagnostic bit n reports channel n+1
// R18: Reset pin low clears register, outputs off
// R19: Overload limits current, flags that channel
// R20: Overheated channel cycles on and off alone
// R21: Master clock period at least 200 ns
// R22: Master waits 250 ns lead and lag
// R23: Diagnostic equals control bit, inverted on fault
// R24: Faults latch until next select rise
// R25: Fault output pulls low on any error; over temperature alone does not pull it here
// R26: Extra clocks pass bits through for chaining
`timescale 1ns/1ps
`include "switch_spi_defines.vh"

module octal_switch_spi_control #(
  parameter NCH                                 = `SW_NCH,           // Channels
  parameter NPAR                                = `SW_NPAR,          // Parallel inputs
  parameter [`SW_THERM_CNT_W-1:0] THERM_PERIOD  = `SW_THERM_PERIOD,  // Restart period
  parameter [`SW_THERM_CNT_W-1:0] THERM_ON      = `SW_THERM_ON       // On slice
) (
  input  wire            CORE_CLK_I,        // Core clock, 200 MHz
  input  wire            SYS_RST_I,         // Synchronous reset, active high
  input  wire            CLK_EN_I,          // Clock enable, freezes state when low
  input  wire            SCLK_I,            // Serial clock from master
  input  wire            SI_I,              // Serial data in
  input  wire            CS_N_I,            // Chip select, active low
  input  wire            RESET_N_I,         // Reset pin, active low
  input  wire            OPEN_LOAD_EN_I,    // Open load detection enable pin
  input  wire [NPAR-1:0] PARALLEL_DRIVE_I,  // parallel_drive_ch1..ch4
  input  wire [NCH-1:0]  OVERLOAD_I,        // Per-channel overload sense
  input  wire [NCH-1:0]  OPEN_LOAD_I,       // Per-channel open load sense
  input  wire [NCH-1:0]  OVERTEMP_I,        // Per-channel over temperature
  output reg  [NCH-1:0]  POWER_OUTPUT_O,    // power_output_ch1..ch8 gate drive
  output reg  [NCH-1:0]  CURRENT_LIMIT_O,   // Current limit active per channel
  output reg             SO_O,              // Serial data out level
  output reg             SO_OE_O,           // Serial data out enable
  output reg             FAULT_N_O,         // Fault pin level, always low
  output reg             FAULT_N_OE_O       // Fault pin enable, high pulls low
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam NSYNC = 5 + NPAR + 3 * NCH;

  wire [NSYNC-1:0] sync_in;
  wire [NSYNC-1:0] sync_out;
  wire             sclk_s;
  wire             si_s;
  wire             cs_n_s;
  wire             rst_pin_n_s;
  wire             ol_en_s;
  wire [NPAR-1:0]  par_s;
  wire [NCH-1:0]   ovl_s;
  wire [NCH-1:0]   opl_s;
  wire [NCH-1:0]   ovt_s;

  // Idle levels: clock low, select high, reset pin high
  localparam [NSYNC-1:0] SYNC_RST = {{(NSYNC-5){1'b0}}, 5'h0e};

  assign sync_in = {OVERTEMP_I, OPEN_LOAD_I, OVERLOAD_I, PARALLEL_DRIVE_I,
                    OPEN_LOAD_EN_I, RESET_N_I, CS_N_I, SI_I, SCLK_I};

  pin_sync #(
    .W       (NSYNC),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk_i   (CORE_CLK_I),
    .rst_i   (SYS_RST_I),
    .ce_i    (CLK_EN_I),
    .async_i (sync_in),
    .sync_o  (sync_out)
  );

  // Unpack synchronised pins
  assign sclk_s      = sync_out[0];
  assign si_s        = sync_out[1];
  assign cs_n_s      = sync_out[2];
  assign rst_pin_n_s = sync_out[3];
  assign ol_en_s     = sync_out[4];
  assign par_s       = sync_out[5 +: NPAR];
  assign ovl_s       = sync_out[5 + NPAR +: NCH];
  assign opl_s       = sync_out[5 + NPAR + NCH +: NCH];
  assign ovt_s       = sync_out[5 + NPAR + 2 * NCH +: NCH];

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on the serial pins
  reg  sclk_d_q;
  reg  cs_n_d_q;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;
  wire cs_rise;

  // Previous levels of the synchronised clock and select
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      sclk_d_q <= 1'b0;
      cs_n_d_q <= 1'b1;
    end else if (CLK_EN_I) begin
      sclk_d_q <= sclk_s;
      cs_n_d_q <= cs_n_s;
    end
  end

  // Clock edges only count while selected
  assign sclk_rise = sclk_s & ~sclk_d_q & ~cs_n_s & ~cs_n_d_q;   // [R10]
  assign sclk_fall = ~sclk_s & sclk_d_q & ~cs_n_s & ~cs_n_d_q;   // [R10]
  assign cs_fall   = ~cs_n_s & cs_n_d_q;
  assign cs_rise   = cs_n_s & ~cs_n_d_q;

  //////////////////////////////////////////////////////////////////////////////
  // Serial shift register, latches and diagnostics
  reg  [NCH-1:0] shift_q;
  reg  [NCH-1:0] shift_d;
  reg  [NCH-1:0] ctrl_q;
  reg  [NCH-1:0] ctrl_d;
  reg            clk_seen_q;
  reg            clk_seen_d;
  wire           frame_done;
  wire [NCH-1:0] on_cmd;
  wire [NCH-1:0] allow;
  wire [NCH-1:0] diag;
  wire [NCH-1:0] fault;

  // A select rise counts only after a valid clock in the frame
  assign frame_done = cs_rise & clk_seen_q;   // [R11]

  // Serial bit n or its parallel input drives channel n+1
  assign on_cmd = ctrl_q | {{(NCH-NPAR){1'b0}}, par_s};   // [R14] [R15] [R16] [R05]

  // Next state of shift register, latches and clock-seen flag
  always @* begin
    shift_d    = shift_q;
    ctrl_d     = ctrl_q;
    clk_seen_d = clk_seen_q;
    if (!rst_pin_n_s) begin
      shift_d    = `SW_SHIFT_RST;   // [R18]
      ctrl_d     = `SW_CTRL_RST;    // [R18]
      clk_seen_d = 1'b0;
    end else if (cs_fall) begin
      shift_d    = diag;            // [R08] [R17]
      clk_seen_d = 1'b0;
    end else if (sclk_fall) begin
      shift_d    = {shift_q[NCH-2:0], si_s};  // [R01] [R03] [R26]
      clk_seen_d = 1'b1;
    end else if (frame_done) begin
      ctrl_d     = shift_q;         // [R06]
      clk_seen_d = 1'b0;
    end else if (cs_rise) begin
      clk_seen_d = 1'b0;
    end
  end

  // Register the serial state
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      shift_q    <= `SW_SHIFT_RST;
      ctrl_q     <= `SW_CTRL_RST;
      clk_seen_q <= 1'b0;
    end else if (CLK_EN_I) begin
      shift_q    <= shift_d;
      ctrl_q     <= ctrl_d;
      clk_seen_q <= clk_seen_d;
    end
  end

  // One fault and thermal monitor per channel
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      channel_diag #(
        .THERM_PERIOD (THERM_PERIOD),
        .THERM_ON     (THERM_ON)
      ) u_diag (
        .clk_i       (CORE_CLK_I),
        .rst_i       (SYS_RST_I),
        .ce_i        (CLK_EN_I),
        .on_i        (on_cmd[c]),
        .ctrl_bit_i  (ctrl_q[c]),
        .overload_i  (ovl_s[c]),
        .open_load_i (opl_s[c]),
        .overtemp_i  (ovt_s[c]),
        .ol_en_i     (ol_en_s),
        .clear_i     (frame_done),   // [R07]
        .allow_o     (allow[c]),
        .diag_o      (diag[c]),
        .fault_o     (fault[c])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Serial output pin
  // Drives the MSB from select fall, next bit after each rising clock
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      SO_O    <= 1'b0;
      SO_OE_O <= 1'b0;
    end else if (CLK_EN_I) begin
      if (cs_n_s) begin
        SO_OE_O <= 1'b0;                  // [R09]
      end else if (cs_fall) begin
        SO_OE_O <= 1'b1;                  // [R09]
        SO_O    <= diag[`SW_MSB];         // [R04]
      end else if (sclk_rise) begin
        SO_O    <= shift_q[`SW_MSB];      // [R02] [R26]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power outputs, current limit and fault pin
  // Reset pin forces all gates off; thermal cycling gates each channel
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      POWER_OUTPUT_O  <= {NCH{1'b0}};
      CURRENT_LIMIT_O <= {NCH{1'b0}};
      FAULT_N_O       <= 1'b0;
      FAULT_N_OE_O    <= 1'b0;
    end else if (CLK_EN_I) begin
      if (!rst_pin_n_s) begin
        POWER_OUTPUT_O  <= {NCH{1'b0}};   // [R18]
        CURRENT_LIMIT_O <= {NCH{1'b0}};
      end else begin
        POWER_OUTPUT_O  <= on_cmd & allow;        // [R05] [R20]
        CURRENT_LIMIT_O <= on_cmd & ovl_s;        // [R19]
      end
      FAULT_N_O    <= 1'b0;
      FAULT_N_OE_O <= |fault;                     // [R25] [R19]
    end
  end

endmodule

// *** tb/switch_checker.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module switch_checker (
  input logic       CORE_CLK_I,        // Clock
  input logic       SYS_RST_I,         // Reset
  input logic       SCLK_I,            // Serial clock
  input logic       CS_N_I,            // Select
  input logic       RESET_N_I,         // Reset pin
  input logic [3:0] PARALLEL_DRIVE_I,  // Parallel drive
  input logic [7:0] OVERLOAD_I,        // Overload sense
  input logic [7:0] OVERTEMP_I,        // Overtemp sense
  input logic [7:0] POWER_OUTPUT_O,    // Gate drive
  input logic [7:0] CURRENT_LIMIT_O,   // Current limit
  input logic       SO_O,              // Serial out
  input logic       SO_OE_O,           // Serial out enable
  input logic       FAULT_N_OE_O       // Fault pull-down
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Quiet stretches long enough to pass the synchronisers
  sequence desel_s; CS_N_I [*6]; endsequence
  sequence sel_quiet_s; (!CS_N_I && !SCLK_I) [*6]; endsequence
  sequence pin_low_s; !RESET_N_I [*6]; endsequence
  sequence ch1_load_s; (RESET_N_I && OVERLOAD_I[0] && POWER_OUTPUT_O[0]) [*6]; endsequence
  // Serial output enable and level
  a_so_float: assert property (desel_s |-> !SO_OE_O)
    else $error("serial out driven while deselected");
  a_so_enable: assert property ($fell(CS_N_I) |-> ##[2:5] SO_OE_O)
    else $error("serial out not enabled after select");
  a_so_release: assert property ($rose(CS_N_I) |-> ##[2:5] !SO_OE_O)
    else $error("serial out not released after deselect");
  a_so_hold: assert property (sel_quiet_s |-> $stable(SO_O))
    else $error("serial out moved without a clock rise");
  // Output stage
  a_pin_off: assert property (pin_low_s |-> POWER_OUTPUT_O == 8'h00)
    else $error("outputs on while reset pin low");
  a_par_or: assert property ((RESET_N_I && PARALLEL_DRIVE_I[0] && !OVERTEMP_I[0]) [*6]
    |-> POWER_OUTPUT_O[0])
    else $error("parallel drive did not switch channel on");
  a_desel_hold: assert property ((CS_N_I && RESET_N_I && $stable(PARALLEL_DRIVE_I)
    && OVERTEMP_I == 8'h00) [*8] |-> $stable(POWER_OUTPUT_O))
    else $error("outputs changed while deselected");
  // Protection and fault flag
  a_cur_limit: assert property (ch1_load_s |-> CURRENT_LIMIT_O[0])
    else $error("no current limit under overload");
  a_fault_pin: assert property (ch1_load_s |-> FAULT_N_OE_O)
    else $error("fault line not pulled low");
endmodule

// *** tb/spi_master_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module spi_master_model (
  input  logic clk_i,    // Core clock
  input  logic so_i,     // Serial out level
  input  logic so_oe_i,  // Serial out enable
  output logic sclk_o,   // Serial clock
  output logic si_o,     // Serial data
  output logic cs_n_o    // Select, active low
);
  localparam int HALF = 20;  // 100 ns phases, 200 ns period
  localparam int GAP  = 50;  // 250 ns lead and lag
  initial begin
    sclk_o = 1'b0;
    si_o = 1'b0;
    cs_n_o = 1'b1;
  end
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Select edges only with the clock low, frame kept inside
  task automatic sel(input logic on);
    wait_c(GAP);
    cs_n_o <= ~on;
    wait_c(GAP);
  endtask
  // Data set after the fall, output read at the end of the high phase
  task automatic bit_x(input logic b, output logic r);
    wait_c(5);
    si_o <= b;
    wait_c(HALF - 5);
    sclk_o <= 1'b1;
    wait_c(HALF);
    r = so_oe_i ? so_i : ~so_i;
    sclk_o <= 1'b0;
  endtask
  task automatic xfer8(input logic [7:0] tx, output logic [7:0] rx);
    sel(1'b1);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    sel(1'b0);
  endtask
  task automatic xfer16(input logic [15:0] tx, output logic [15:0] rx);
    sel(1'b1);
    for (int i = 15; i >= 0; i--) bit_x(tx[i], rx[i]);
    sel(1'b0);
  endtask
  task automatic empty_sel();
    sel(1'b1);
    sel(1'b0);
  endtask
  // Clock and data pulses while deselected
  task automatic stray();
    repeat (4) begin
      si_o <= ~si_o;
      sclk_o <= 1'b1;
      wait_c(HALF);
      sclk_o <= 1'b0;
      wait_c(HALF);
    end
  endtask
endmodule

// *** tb/tb_octal_switch_spi_control.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module tb_octal_switch_spi_control;
  logic        core_clk, sys_rst, reset_n, sclk, si, cs_n, so, so_oe, fault_oe;
  logic [3:0]  par;
  logic [7:0]  ovl, otemp, pwr, ilim, rx;
  logic [15:0] rx16;
  int          err_total = 0, n_checks = 0, cyc = 0;
  octal_switch_spi_control #(.THERM_PERIOD(16'd20), .THERM_ON(16'd4)) uut (
    .CORE_CLK_I(core_clk), .SYS_RST_I(sys_rst), .CLK_EN_I(1'b1), .SCLK_I(sclk),
    .SI_I(si), .CS_N_I(cs_n), .RESET_N_I(reset_n), .OPEN_LOAD_EN_I(1'b0),
    .PARALLEL_DRIVE_I(par), .OVERLOAD_I(ovl), .OPEN_LOAD_I(8'h00), .OVERTEMP_I(otemp),
    .POWER_OUTPUT_O(pwr), .CURRENT_LIMIT_O(ilim), .SO_O(so), .SO_OE_O(so_oe),
    .FAULT_N_O(), .FAULT_N_OE_O(fault_oe));
  spi_master_model master (.clk_i(core_clk), .so_i(so), .so_oe_i(so_oe),
    .sclk_o(sclk), .si_o(si), .cs_n_o(cs_n));
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_walk();
    for (int k = 0; k < 8; k++) begin
      master.xfer8(8'h01 << k, rx);
      chk(rx, k == 0 ? 8'h00 : 8'h01 << (k - 1));
      chk(pwr, 8'h01 << k);
    end
    $display("test walk done");
  endtask
  task automatic t_par();
    @(posedge core_clk) par <= 4'hf;
    master.xfer8(8'ha0, rx);
    chk(pwr, 8'haf);
    master.xfer8(8'ha0, rx);
    chk(rx, 8'ha0);
    @(posedge core_clk) par <= 4'h0;
    wc(8);
    chk(pwr, 8'ha0);
    $display("test parallel done");
  endtask
  task automatic t_ignore();
    master.stray();
    master.empty_sel();
    chk(pwr, 8'ha0);
    master.xfer8(8'h00, rx);
    chk(rx, 8'ha0);
    $display("test ignore done");
  endtask
  task automatic t_daisy();
    master.xfer16(16'h3c5a, rx16);
    chk(rx16, 16'h003c);
    chk(pwr, 8'h5a);
    $display("test chain done");
  endtask
  task automatic t_fault();
    master.xfer8(8'h01, rx);
    @(posedge core_clk) ovl <= 8'h01;
    wc(8);
    chk(ilim, 8'h01);
    chk(fault_oe, 1'b1);
    @(posedge core_clk) ovl <= 8'h00;
    master.empty_sel();
    chk(fault_oe, 1'b1);
    master.xfer8(8'h01, rx);
    chk(rx, 8'h00);
    chk(fault_oe, 1'b0);
    $display("test fault done");
  endtask
  task automatic t_pin();
    @(posedge core_clk) begin
      par <= 4'h2;
      reset_n <= 1'b0;
    end
    wc(8);
    chk(pwr, 8'h00);
    @(posedge core_clk) reset_n <= 1'b1;
    wc(8);
    chk(pwr, 8'h02);
    @(posedge core_clk) par <= 4'h0;
    $display("test reset pin done");
  endtask
  task automatic t_therm();
    logic [15:0] on_n;
    master.xfer8(8'h81, rx);
    @(posedge core_clk) otemp <= 8'h80;
    wc(20);
    on_n = 16'h0000;
    repeat (200) begin
      @(posedge core_clk);
      on_n += pwr[7];
    end
    chk(on_n, 16'd40);
    chk(pwr[0], 1'b1);
    @(posedge core_clk) otemp <= 8'h00;
    $display("test thermal done");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    reset_n = 1'b1;
    par = 4'h0;
    ovl = 8'h00;
    otemp = 8'h00;
    wc(5);
    sys_rst <= 1'b0;
    wc(2);
    chk(pwr, 8'h00);
    chk(so_oe, 1'b0);
    t_walk();
    t_par();
    t_ignore();
    t_daisy();
    t_fault();
    t_pin();
    t_therm();
    print_verdict();
  end
endmodule
bind octal_switch_spi_control switch_checker chk_i (
  .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .SCLK_I(SCLK_I), .CS_N_I(CS_N_I),
  .RESET_N_I(RESET_N_I), .PARALLEL_DRIVE_I(PARALLEL_DRIVE_I), .OVERLOAD_I(OVERLOAD_I),
  .OVERTEMP_I(OVERTEMP_I), .POWER_OUTPUT_O(POWER_OUTPUT_O), .SO_O(SO_O),
  .CURRENT_LIMIT_O(CURRENT_LIMIT_O), .SO_OE_O(SO_OE_O), .FAULT_N_OE_O(FAULT_N_OE_O));
